// >>> hdl/ssw_defs.svh
`ifndef SSW_DEFS_SVH
`define SSW_DEFS_SVH
`define SSW_CLK_HZ          20000000
`define SSW_MS_CYC          (`SSW_CLK_HZ / 1000)
`define SSW_INIT_MS         256
`define SSW_STUCK_MS        8000
`define SSW_LFSR_RST        8'hB2
`define SSW_WIN_RST         4'h2
`define SSW_RSTDUR_RST      2'h0
`define SSW_WDERR_MAX       4'h6
`define SSW_WDERR_INC       4'h2
`define SSW_FLT_INT0        3'h3
`define SSW_FLT_FIN0        3'h6
`define SSW_FLT_INT1        3'h1
`define SSW_FLT_FIN1        3'h2
`endif

// >>> hdl/ssw_pkg.sv
package ssw_pkg;
  typedef enum logic [5:0] {
    SSW_SELFTEST = 6'h01,
    SSW_WAIT_PRE = 6'h02,
    SSW_RST_LOW  = 6'h04,
    SSW_INIT     = 6'h08,
    SSW_NORMAL   = 6'h10,
    SSW_DEEP     = 6'h20
  } ssw_state_t;
endpackage

// >>> hdl/ssw_watchdog.sv
`timescale 1ns/1ps
`default_nettype none
`include "ssw_defs.svh"
// Behaviour
// - second self-test runs only on host command
// - critical aux holds primary safe output until pass
// - init phase starts at reset release
// - init-only settings locked after init
// - first good answer enters normal watchdog
// - reset assertion leaves normal watchdog
// - timed reset low, release only without faults
// - safe outputs run beside main states
// - fault final or stuck reset enters deep
// - deep state: regulators off, outputs asserted
// - key low to low-power-off, high wakes
// - stuck timer from preregulator wait to release
// - stuck timer disable in init, restart
// - three active-low safety outputs
// - closed window access is wrong refresh
// - window period selectable from fixed table
// - inhibit by write or debug strap
// - 8-bit lfsr challenge, optional host seed
// - good answer advances lfsr, restarts window
// - wrong answer counts, restarts, irq, lfsr kept
// - error counter plus two, minus one
// - fixed half closed, half open
// - open window timeout is wrong refresh
// - fault thresholds 3/6 or 1/2
module ssw_watchdog
  import ssw_pkg::*;
#(
  parameter int unsigned MS_CYC    = `SSW_MS_CYC,
  parameter int unsigned INIT_CYC  = `SSW_INIT_MS * `SSW_MS_CYC,
  parameter int unsigned STUCK_CYC = `SSW_STUCK_MS * `SSW_MS_CYC,
  parameter logic [7:0]  ANS_XOR   = 8'hFF
) (
  // clock and own power-on reset
  input  wire logic       clock_i,
  input  wire logic       rst_i,
  // status from analog side and self-tests
  input  wire logic       selftests_done_i,
  input  wire logic       selftests_ok_i,
  input  wire logic       prereg_ok_i,
  input  wire logic       fault_i,
  input  wire logic       analog_selftest_second_pass_i,
  input  wire logic       analog_selftest_second_done_i,
  // pins
  input  wire logic       host_reset_in_i,
  input  wire logic       key_i,
  input  wire logic       debug_strap_i,
  // host commands, one-cycle strobes
  input  wire logic       analog_selftest_second_req_i,
  input  wire logic       answer_wr_i,
  input  wire logic [7:0] answer_i,
  input  wire logic       seed_wr_i,
  input  wire logic [7:0] seed_i,
  input  wire logic       window_wr_i,
  input  wire logic [3:0] window_i,
  input  wire logic       cfg_wr_i,
  input  wire logic [1:0] rst_dur_i,
  input  wire logic       aux_critical_i,
  input  wire logic       stuck_dis_i,
  input  wire logic       wd_inhibit_i,
  input  wire logic       flt_sel_i,
  // outputs
  output var  logic       host_reset_out_n_o,
  output var  logic       safe_out_primary_n_o,
  output var  logic       safe_out_secondary_n_o,
  output var  logic       host_irq_n_o,
  output var  logic       analog_selftest_second_start_o,
  output var  logic       regulators_on_o,
  output var  logic       low_power_off_o,
  output var  logic [7:0] challenge_o,
  output var  logic [5:0] state_o,
  output var  logic [2:0] fault_cnt_o,
  output var  logic [3:0] wd_err_cnt_o
);

  function automatic logic [7:0] ssw_expect(input logic [7:0] c);
    return ~(c ^ ANS_XOR) ^ 8'hFF ^ {c[0], c[7:1]};
  endfunction

  function automatic logic [10:0] ssw_win_ms(input logic [3:0] s);
    case (s)
      4'h0: return 11'd1;    4'h1: return 11'd2;    4'h2: return 11'd3;
      4'h3: return 11'd4;    4'h4: return 11'd6;    4'h5: return 11'd8;
      4'h6: return 11'd12;   4'h7: return 11'd16;   4'h8: return 11'd24;
      4'h9: return 11'd32;   4'hA: return 11'd64;   4'hB: return 11'd128;
      4'hC: return 11'd256;  4'hD: return 11'd512;  default: return 11'd1024;
    endcase
  endfunction

  typedef struct packed {
    logic [1:0]  rin_s;
    logic [1:0]  key_s;
    logic [1:0]  dbg_s;
    ssw_state_t  st;
    logic        debug;
    logic [7:0]  lfsr;
    logic [3:0]  win_cur;
    logic [3:0]  win_cfg;
    logic [1:0]  rst_dur;
    logic        aux_crit;
    logic        stuck_dis;
    logic        inhibit;
    logic        flt_sel;
    logic [31:0] tmr;
    logic [31:0] stuck;
    logic        stuck_run;
    logic [3:0]  wd_err;
    logic [2:0]  flt;
    logic        analog_selftest_second_ok;
    logic        low_power_off;
    logic        rst_n;
    logic        fs0_n;
    logic        fs1_n;
    logic        irq_n;
    logic        a2_start;
  } ssw_reg_t;

  ssw_reg_t r;
  ssw_reg_t next_r;

  logic [31:0] half_cyc;
  logic        win_open;
  logic        good;
  logic        bad_ans;
  logic        timeout;
  logic        wd_fail;
  logic [2:0]  flt_int;
  logic [2:0]  flt_fin;

  always_comb begin
    half_cyc = ((32'(ssw_win_ms(r.win_cur)) * 32'(MS_CYC)) >> 1);
    win_open = (r.st == SSW_INIT) || (r.tmr >= half_cyc);
    good     = answer_wr_i && win_open && (answer_i == ssw_expect(r.lfsr));
    bad_ans  = answer_wr_i && !good;
    timeout  = (r.st == SSW_INIT) ? (r.tmr >= 32'(INIT_CYC) - 32'd1)
                                  : (r.tmr >= (half_cyc << 1) - 32'd1);
    wd_fail  = bad_ans || (timeout && !answer_wr_i);
    flt_int  = r.flt_sel ? `SSW_FLT_INT1 : `SSW_FLT_INT0;
    flt_fin  = r.flt_sel ? `SSW_FLT_FIN1 : `SSW_FLT_FIN0;
  end

  always_comb begin
    next_r          = r;
    next_r.rin_s    = {r.rin_s[0], host_reset_in_i};
    next_r.key_s    = {r.key_s[0], key_i};
    next_r.dbg_s    = {r.dbg_s[0], debug_strap_i};
    next_r.irq_n    = 1'b1;
    next_r.a2_start = 1'b0;
    if (r.stuck_run && r.stuck < 32'(STUCK_CYC)) begin
      next_r.stuck = r.stuck + 32'd1;
    end
    if (analog_selftest_second_req_i) begin
      next_r.a2_start = 1'b1;
    end
    if (analog_selftest_second_done_i) begin
      next_r.analog_selftest_second_ok = analog_selftest_second_pass_i;
    end
    if (window_wr_i && (r.st == SSW_INIT || r.st == SSW_NORMAL)) begin
      next_r.win_cfg = window_i;
    end
    case (r.st)
      SSW_SELFTEST: begin
        if (selftests_done_i) begin
          next_r.debug     = r.dbg_s[1];
          next_r.st        = SSW_WAIT_PRE;
          next_r.stuck_run = 1'b1;
          next_r.stuck     = 32'd0;
        end
      end
      SSW_WAIT_PRE: begin
        if (prereg_ok_i) begin
          next_r.st  = SSW_RST_LOW;
          next_r.tmr = 32'd0;
        end
      end
      SSW_RST_LOW: begin
        next_r.tmr = r.tmr + 32'd1;
        if (r.tmr >= (32'd1 << r.rst_dur) * 32'(MS_CYC) && !fault_i) begin
          next_r.rst_n = 1'b1;
          // host may hold the line low; init waits until the pin is seen high
          if (r.rst_n && r.rin_s[1]) begin
            next_r.st        = SSW_INIT;
            next_r.tmr       = 32'd0;
            next_r.stuck_run = 1'b0;
          end
        end else begin
          next_r.rst_n = 1'b0;
        end
      end
      SSW_INIT, SSW_NORMAL: begin
        next_r.tmr = r.tmr + 32'd1;
        if (r.st == SSW_INIT && cfg_wr_i) begin
          next_r.rst_dur   = rst_dur_i;
          next_r.aux_crit  = aux_critical_i;
          next_r.stuck_dis = stuck_dis_i;
          next_r.inhibit   = wd_inhibit_i;
          next_r.flt_sel   = flt_sel_i;
        end
        if (r.st == SSW_INIT && seed_wr_i) begin
          next_r.lfsr = seed_i;
        end
        if (good) begin
          next_r.lfsr    = {r.lfsr[6:0], r.lfsr[7] ^ r.lfsr[5] ^ r.lfsr[4] ^ r.lfsr[3]};
          next_r.tmr     = 32'd0;
          next_r.win_cur = r.win_cfg;
          next_r.wd_err  = (r.wd_err != 4'h0) ? r.wd_err - 4'h1 : 4'h0;
          next_r.st      = SSW_NORMAL;
        end else if (wd_fail) begin
          next_r.tmr     = 32'd0;
          next_r.win_cur = r.win_cfg;
          next_r.irq_n   = 1'b0;
          next_r.wd_err  = (r.wd_err >= `SSW_WDERR_MAX - `SSW_WDERR_INC) ?
                           `SSW_WDERR_MAX : r.wd_err + `SSW_WDERR_INC;
        end
        // watchdog failure resets only when watchdog may act, debug strap mutes it; fault or low reset pin always resets
        if ((wd_fail && !r.inhibit && !r.debug && (r.st == SSW_INIT ||
             r.wd_err >= `SSW_WDERR_MAX - `SSW_WDERR_INC)) || fault_i || !r.rin_s[1]) begin
          next_r.st    = SSW_RST_LOW;
          next_r.rst_n = 1'b0;
          next_r.tmr   = 32'd0;
          next_r.wd_err = 4'h0;
          next_r.flt   = (r.flt < 3'h7) ? r.flt + 3'h1 : r.flt;
          next_r.fs0_n = 1'b0;
          if (!r.stuck_dis) begin
            next_r.stuck_run = 1'b1;
            next_r.stuck     = 32'd0;
          end
        end
      end
      SSW_DEEP: begin
        next_r.rst_n = 1'b0;
        next_r.fs0_n = 1'b0;
        next_r.fs1_n = 1'b0;
        if (!r.key_s[1]) begin
          next_r.low_power_off = 1'b1;
        end else if (r.low_power_off) begin
          next_r       = '0;
          next_r.st    = SSW_SELFTEST;
          next_r.lfsr  = `SSW_LFSR_RST;
          next_r.win_cur = `SSW_WIN_RST;
          next_r.win_cfg = `SSW_WIN_RST;
          next_r.irq_n = 1'b1;
          next_r.fs0_n = 1'b0;
          next_r.fs1_n = 1'b0;
        end
      end
      default: next_r.st = SSW_SELFTEST;
    endcase
    // safe outputs follow fault state beside the main sequence
    if (r.st == SSW_INIT || r.st == SSW_NORMAL) begin
      next_r.fs0_n = selftests_ok_i && (r.analog_selftest_second_ok || !r.aux_crit) && r.flt < flt_int
                     && !fault_i;
      next_r.fs1_n = selftests_ok_i && r.flt < flt_int && !fault_i;
    end
    if (r.st != SSW_DEEP && r.st != SSW_SELFTEST &&
        (r.flt >= flt_fin || (r.stuck_run && r.stuck >= 32'(STUCK_CYC)))) begin
      next_r.st    = SSW_DEEP;
      next_r.rst_n = 1'b0;
      next_r.fs0_n = 1'b0;
      next_r.fs1_n = 1'b0;
      next_r.stuck_run = 1'b0;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      r         <= '0;
      r.st      <= SSW_SELFTEST;
      r.lfsr    <= `SSW_LFSR_RST;
      r.win_cur <= `SSW_WIN_RST;
      r.win_cfg <= `SSW_WIN_RST;
      r.rst_dur <= `SSW_RSTDUR_RST;
      r.irq_n   <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  always_comb begin
    host_reset_out_n_o     = r.rst_n;
    safe_out_primary_n_o   = r.fs0_n;
    safe_out_secondary_n_o = r.fs1_n;
    host_irq_n_o           = r.irq_n;
    analog_selftest_second_start_o         = r.a2_start;
    regulators_on_o        = (r.st != SSW_DEEP);
    low_power_off_o        = r.low_power_off;
    challenge_o            = r.lfsr;
    state_o                = r.st;
    fault_cnt_o            = r.flt;
    wd_err_cnt_o           = r.wd_err;
  end

  //////////////////////////////////////////////////////////////////////////////
  a_deep_outs: assert property (@(posedge clock_i) disable iff (rst_i)
    (r.st == SSW_DEEP) |=> !r.rst_n && !r.fs0_n && !r.fs1_n)
    else $error("deep state outputs not asserted");
  a_wrong_irq: assert property (@(posedge clock_i) disable iff (rst_i)
    (r.st == SSW_NORMAL && bad_ans) |=> !r.irq_n && $stable(r.lfsr))
    else $error("wrong answer handling");
  a_good_lfsr: assert property (@(posedge clock_i) disable iff (rst_i)
    good |=> r.lfsr != $past(r.lfsr) && r.tmr == 32'd0)
    else $error("good answer did not advance");
  a_init_enter: assert property (@(posedge clock_i) disable iff (rst_i)
    (r.st == SSW_RST_LOW && next_r.st == SSW_INIT) |=> r.rst_n)
    else $error("init without release");
  a_deep_fault: assert property (@(posedge clock_i) disable iff (rst_i)
    (r.flt >= flt_fin && r.st == SSW_NORMAL) |=> r.st == SSW_DEEP)
    else $error("final fault not deep");
  a_cfg_lock: assert property (@(posedge clock_i) disable iff (rst_i)
    (r.st == SSW_NORMAL && cfg_wr_i) |=> $stable(r.rst_dur))
    else $error("locked setting changed");
  a_first_good: assert property (@(posedge clock_i) disable iff (rst_i)
    (r.st == SSW_INIT && good && !fault_i && r.rin_s[1]) |=> r.st == SSW_NORMAL)
    else $error("first answer not normal");
  a_key_low_power_off: assert property (@(posedge clock_i) disable iff (rst_i)
    (r.st == SSW_DEEP && !r.key_s[1]) |=> r.low_power_off)
    else $error("key low not low-power-off");

endmodule // ssw_watchdog
`default_nettype wire

// >>> verif/safety_state_machine_watchdog_tb.sv
`timescale 1ns/1ps
`default_nettype none
module safety_state_machine_watchdog_tb;
  import ssw_pkg::*;
  localparam int unsigned MS = 20;
  logic clock_i = 0, rst_i = 1, done = 0, ok = 0, pre = 0, a2p = 0, a2d = 0, rin = 1, key = 1;
  logic a2r = 0, swr = 0, wwr = 0, cwr = 0, awr, rout_n, p_n, s_n, irq_n, a2s, reg_on, lpo;
  logic auxc = 0, sdis = 0, inh = 0, fsel = 0;
  logic [1:0] rdur = 2'h0;
  logic [7:0] seed = 8'h00, ans, chal, c;
  logic [3:0] win = 4'h2, ec;
  logic [5:0] st;
  logic [2:0] fc;
  int failures = 0, check_count = 0, cyc = 0, n;
  always #25 clock_i = ~clock_i;
  ssw_watchdog #(.MS_CYC(MS), .INIT_CYC(5120), .STUCK_CYC(2000), .ANS_XOR(8'hFF)) u_dut (
    .clock_i(clock_i), .rst_i(rst_i), .selftests_done_i(done), .selftests_ok_i(ok),
    .prereg_ok_i(pre), .fault_i(1'b0), .analog_selftest_second_pass_i(a2p), .analog_selftest_second_done_i(a2d),
    .host_reset_in_i(rin), .key_i(key), .debug_strap_i(1'b0), .analog_selftest_second_req_i(a2r),
    .answer_wr_i(awr), .answer_i(ans), .seed_wr_i(swr), .seed_i(seed), .window_wr_i(wwr),
    .window_i(win), .cfg_wr_i(cwr), .rst_dur_i(rdur), .aux_critical_i(auxc),
    .stuck_dis_i(sdis), .wd_inhibit_i(inh), .flt_sel_i(fsel),
    .host_reset_out_n_o(rout_n), .safe_out_primary_n_o(p_n), .safe_out_secondary_n_o(s_n),
    .host_irq_n_o(irq_n), .analog_selftest_second_start_o(a2s), .regulators_on_o(reg_on),
    .low_power_off_o(lpo), .challenge_o(chal), .state_o(st), .fault_cnt_o(fc),
    .wd_err_cnt_o(ec));
  ssw_host_model #(.ANS_XOR(8'hFF)) u_host (
    .clock_i(clock_i), .challenge_i(chal), .answer_wr_o(awr), .answer_o(ans));
  ////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge clock_i);
    #2;
  endtask
  // bounded wait, n keeps the cycles spent
  task automatic wait_st(input logic [5:0] v, input int lim);
    for (n = 0; n < lim && st !== v; n++) step(1);
    chk(st, v);
  endtask
  // pulses last one cycle, so scan a short span
  task automatic see_low(input logic sig_sel);
    logic hit;
    hit = 0;
    for (int i = 0; i < 3; i++) begin
      if ((sig_sel ? a2s : ~irq_n) === 1'b1) hit = 1;
      step(1);
    end
    chk(hit, 1);
  endtask
  task automatic final_report;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  ////////////////////////////////////////
  task automatic t_reset;
    chk(st, SSW_SELFTEST);
    chk({rout_n, p_n, s_n, irq_n}, 8'h01);
    chk(chal, 8'hB2);
    $display("test reset done");
  endtask
  task automatic t_powerup;
    done = 1;
    ok = 1;
    wait_st(SSW_WAIT_PRE, 10);
    pre = 1;
    wait_st(SSW_RST_LOW, 10);
    chk(rout_n, 0);
    wait_st(SSW_INIT, MS + 10);
    chk(n >= MS - 3 && n <= MS + 3, 1);
    chk(rout_n, 1);
    $display("test powerup done");
  endtask
  task automatic t_init;
    a2r = 1;
    step(1);
    a2r = 0;
    see_low(1);
    a2d = 1;
    a2p = 1;
    rdur = 2'h0;
    auxc = 1;
    sdis = 0;
    inh = 0;
    fsel = 0;
    cwr = 1; // config before first answer
    seed = 8'h5A;
    swr = 1;
    step(1);
    cwr = 0;
    swr = 0;
    step(2);
    chk(p_n, 1);
    chk(chal, 8'h5A);
    chk(st, SSW_INIT);
    u_host.answer(0);
    wait_st(SSW_NORMAL, 5);
    chk(chal !== 8'h5A, 1);
    c = chal;
    seed = 8'h33;
    swr = 1;
    step(1);
    swr = 0;
    step(3);
    chk(chal, c);
    $display("test init done");
  endtask
  // default window 3 ms: closed 30, open 30 cycles
  task automatic t_window;
    u_host.answer(0);
    see_low(0);
    chk(ec, 4'h2);
    chk(chal, c);
    step(38);
    u_host.answer(0);
    step(3);
    chk(ec, 4'h1);
    chk(chal !== c, 1);
    for (n = 0; n < 80 && ec !== 4'h3; n++) step(1);
    chk(ec, 4'h3);
    chk(n >= 52 && n <= 64, 1);
    wwr = 1;
    win = 4'h0;
    step(1);
    wwr = 0;
    $display("test window done");
  endtask
  task automatic t_deep;
    rin = 0;
    wait_st(SSW_RST_LOW, 8);
    chk(rout_n, 0);
    wait_st(SSW_DEEP, 2100);
    chk(n >= 1980, 1);
    chk({rout_n, p_n, s_n, reg_on}, 8'h00);
    key = 0;
    for (n = 0; n < 8 && lpo !== 1'b1; n++) step(1);
    chk(lpo, 1);
    key = 1;
    rin = 1;
    wait_st(SSW_SELFTEST, 8);
    $display("test deep done");
  endtask
  ////////////////////////////////////////
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 6000) begin
      failures++;
      final_report();
    end
  end
  initial begin
    step(10);
    rst_i = 0;
    t_reset();
    t_powerup();
    t_init();
    t_window();
    t_deep();
    final_report();
  end
endmodule // safety_state_machine_watchdog_tb
`default_nettype wire

// >>> verif/ssw_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module ssw_host_model #(
  parameter logic [7:0] ANS_XOR = 8'hFF
) (
  // clock and challenge
  input  wire logic       clock_i,
  input  wire logic [7:0] challenge_i,
  // answer toward watchdog
  output var  logic       answer_wr_o,
  output var  logic [7:0] answer_o
);
  initial begin
    answer_wr_o = 1'b0;
    answer_o    = 8'h00;
  end
  ////////////////////////////////////////
  // bad flips one bit, only when a test asks
  task automatic answer(input logic bad);
    @(posedge clock_i);
    #2;
    answer_wr_o = 1'b1;
    answer_o    = ~(challenge_i ^ ANS_XOR) ^ 8'hFF ^ {challenge_i[0], challenge_i[7:1]};
    answer_o    = answer_o ^ {7'h00, bad};
    @(posedge clock_i);
    #2;
    answer_wr_o = 1'b0;
    answer_o    = ~answer_o; // released bus shows no stale value
  endtask
endmodule // ssw_host_model
`default_nettype wire
